// ---- logic/hdv_pkg.sv ----
// hdv_pkg: constants shared by the hardware divider and its bench.
// assumes a single 100 MHz system clock and plain strobe ports, no bus.
package hdv_pkg;
  // clock and data geometry
  localparam int unsigned HDV_CLK_PERIOD_NS = 10;
  localparam int unsigned HDV_DATA_W = 32;
  localparam logic [4:0] HDV_LAST_STEP = 5'h1F; // one quotient bit per cycle, 32 steps
  // read selectors for the result port
  localparam logic [2:0] HDV_SEL_QUOTIENT = 3'h0;
  localparam logic [2:0] HDV_SEL_REMAINDER = 3'h1;
  localparam logic [2:0] HDV_SEL_STATUS = 3'h2;
  localparam logic [2:0] HDV_SEL_DIVIDEND = 3'h3;
  localparam logic [2:0] HDV_SEL_DIVISOR = 3'h4;
  // status word layout
  localparam int unsigned HDV_STAT_BUSY_BIT = 0;
  localparam int unsigned HDV_STAT_OVF_BIT = 1;
  // reset values
  localparam logic [31:0] HDV_DATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    HDV_IDLE,
    HDV_RUN,
    HDV_FIX
  } hdv_state_e;
endpackage : hdv_pkg

// ---- logic/hdv_divider.sv ----
// hdv_divider: iterative 32-bit signed/unsigned divider with held-off reads.
// assumes all inputs synchronous to i_sys_clk and one read request at a time.
//
// Behaviour
// - dividend, divisor, quotient, remainder registers, 32-bit.
// - signedness select picks signed or unsigned division.
// - writing divisor starts division with current dividend.
// - finished division loads quotient and remainder.
// - result or status reads wait until division ends.
// - zero divisor sets overflow flag, interrupt capable.
`timescale 1ns/1ps
`default_nettype none
module hdv_divider (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // register writes
  input wire logic i_dividend_wr,
  input wire logic i_divisor_wr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_signedness_select,
  // register reads
  input wire logic i_rd_req,
  input wire logic [2:0] i_rd_sel,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data,
  // status
  input wire logic i_ovf_clr,
  output logic o_busy,
  output logic o_overflow
);
  import hdv_pkg::*;

  // all state lives in one packed struct:
  // - dividend/divisor hold what software wrote last
  // - quotient/remainder hold the last published result
  // - work_* are the iteration registers, never seen from outside
  // - neg_* remember the sign fix-up chosen at start time
  // - busy is a registered copy of the state decode, so o_busy comes from a flop
  // - rd_* park one read until the divider is idle
  // the work registers are separate from the published ones so a result
  // stays intact while the next operation grinds.
  typedef struct packed {
    hdv_state_e state;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic [31:0] quotient;
    logic [31:0] remainder;
    logic [31:0] work_div;
    logic [31:0] work_quo;
    logic [31:0] work_rem;
    logic [4:0] step;
    logic neg_quo;
    logic neg_rem;
    logic ovf;
    logic busy;
    logic rd_pend;
    logic [2:0] rd_sel;
    logic rd_valid;
    logic [31:0] rd_data;
  } hdv_s;

  hdv_s st_reg;
  hdv_s st_next;

  // magnitude of an operand, two's complement only when signed mode asks
  function automatic logic [31:0] hdv_mag(input logic [31:0] v, input logic sgn);
    hdv_mag = (sgn && v[31]) ? (32'h0000_0000 - v) : v;
  endfunction : hdv_mag

  // busy decode, shared by the status word and the busy flop
  function automatic logic hdv_is_busy(input hdv_state_e s);
    hdv_is_busy = (s != HDV_IDLE);
  endfunction : hdv_is_busy

  logic [32:0] shifted;
  logic [32:0] trial;
  logic [31:0] status_word;
  logic [31:0] dvd_now;

  // one restoring step: shift next dividend bit in and try to subtract.
  // the quotient register doubles as the dividend shift register, so the
  // iteration needs no extra 32-bit store; one quotient bit per clock.
  // the trial is one bit wider than the operands: an unsigned divisor
  // may use all 32 bits, and the borrow out of bit 32 is the compare.
  // limitation: latency is fixed, no early exit for small operands.
  always_comb begin
    shifted = {st_reg.work_rem, st_reg.work_quo[31]};
    trial = shifted - {1'b0, st_reg.work_div};
    status_word = 32'h0000_0000;
    status_word[HDV_STAT_BUSY_BIT] = hdv_is_busy(st_reg.state);
    status_word[HDV_STAT_OVF_BIT] = st_reg.ovf;
    // the dividend that a start sees: a same-cycle dividend write is taken
    dvd_now = i_dividend_wr ? i_wr_data : st_reg.dividend;
  end

  // next-state logic for datapath, flags and read port
  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    // overflow clear first so a same-cycle zero-divisor start wins
    if (i_ovf_clr) begin
      st_next.ovf = 1'b0;
    end
    if (i_dividend_wr) begin
      st_next.dividend = i_wr_data;
    end
    case (st_reg.state)
      HDV_IDLE: begin
      end
      HDV_RUN: begin
        if (!trial[32]) begin
          st_next.work_rem = trial[31:0];
        end else begin
          st_next.work_rem = shifted[31:0];
        end
        st_next.work_quo = {st_reg.work_quo[30:0], ~trial[32]};
        st_next.step = st_reg.step + 5'h01;
        if (st_reg.step == HDV_LAST_STEP) begin
          st_next.state = HDV_FIX;
        end
      end
      HDV_FIX: begin
        // sign correction then publish; quotient negative when signs differ
        st_next.quotient = st_reg.neg_quo ? (32'h0000_0000 - st_reg.work_quo) : st_reg.work_quo;
        st_next.remainder = st_reg.neg_rem ? (32'h0000_0000 - st_reg.work_rem) : st_reg.work_rem;
        st_next.state = HDV_IDLE;
      end
      default: begin
        st_next.state = HDV_IDLE;
      end
    endcase
    // a divisor write always (re)starts, even mid-operation; latest write wins.
    // an operation abandoned in HDV_RUN publishes nothing (one in HDV_FIX still does), so the quotient and
    // remainder keep the last finished result until the new one lands.
    // signed mode works on magnitudes and fixes signs at the end; the one
    // quotient with no positive magnitude (most negative over minus one)
    // wraps back to itself, which software must expect.
    if (i_divisor_wr) begin
      st_next.divisor = i_wr_data;
      // the dividend written in the same cycle is the one used
      st_next.work_quo = hdv_mag(dvd_now, i_signedness_select);
      st_next.work_div = hdv_mag(i_wr_data, i_signedness_select);
      st_next.work_rem = 32'h0000_0000;
      st_next.step = 5'h00;
      st_next.neg_quo = i_signedness_select & (dvd_now[31] ^ i_wr_data[31]);
      st_next.neg_rem = i_signedness_select & dvd_now[31];
      if (i_wr_data == 32'h0000_0000) begin
        // no iteration: quotient 0, remainder keeps the dividend.
        // going through the fix state keeps one publish path for both
        // cases, at the cost of one busy cycle on a zero divisor.
        // the flag is set here after the clear above, so the set wins.
        st_next.ovf = 1'b1;
        st_next.work_quo = 32'h0000_0000;
        st_next.work_rem = dvd_now;
        st_next.neg_quo = 1'b0;
        st_next.neg_rem = 1'b0;
        st_next.state = HDV_FIX;
      end else begin
        st_next.state = HDV_RUN;
      end
    end
    // busy follows the state that will be registered
    st_next.busy = hdv_is_busy(st_next.state);
    // read port: a request is parked until the divider is idle.
    // a request while one is parked is dropped, so the core must wait
    // for the valid pulse. delivery also waits out a cycle with a start,
    // so a read never returns a result that the start is about to replace.
    if (i_rd_req && !st_reg.rd_pend) begin
      st_next.rd_pend = 1'b1;
      st_next.rd_sel = i_rd_sel;
    end
    if (st_reg.rd_pend && (st_reg.state == HDV_IDLE) && !i_divisor_wr) begin
      st_next.rd_pend = 1'b0;
      st_next.rd_valid = 1'b1;
      case (st_reg.rd_sel)
        HDV_SEL_QUOTIENT: st_next.rd_data = st_reg.quotient;
        HDV_SEL_REMAINDER: st_next.rd_data = st_reg.remainder;
        HDV_SEL_STATUS: st_next.rd_data = status_word;
        HDV_SEL_DIVIDEND: st_next.rd_data = st_reg.dividend;
        HDV_SEL_DIVISOR: st_next.rd_data = st_reg.divisor;
        default: st_next.rd_data = 32'h0000_0000;
      endcase
    end
  end

  // state register, synchronous active-low reset.
  // every field gets a constant, so nothing after reset depends on the
  // values that the struct held before it.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg.state <= HDV_IDLE;
      st_reg.dividend <= HDV_DATA_RST;
      st_reg.divisor <= HDV_DATA_RST;
      st_reg.quotient <= HDV_DATA_RST;
      st_reg.remainder <= HDV_DATA_RST;
      st_reg.work_div <= HDV_DATA_RST;
      st_reg.work_quo <= HDV_DATA_RST;
      st_reg.work_rem <= HDV_DATA_RST;
      st_reg.step <= 5'h00;
      st_reg.neg_quo <= 1'b0;
      st_reg.neg_rem <= 1'b0;
      st_reg.ovf <= 1'b0;
      st_reg.busy <= 1'b0;
      st_reg.rd_pend <= 1'b0;
      st_reg.rd_sel <= 3'h0;
      st_reg.rd_valid <= 1'b0;
      st_reg.rd_data <= HDV_DATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops; no decode sits between a flop
  // and a pin, so the core sees clean levels one clock after each event
  assign o_rd_valid = st_reg.rd_valid;
  assign o_rd_data = st_reg.rd_data;
  assign o_busy = st_reg.busy;
  assign o_overflow = st_reg.ovf;
endmodule : hdv_divider
`default_nettype wire

// ---- verif/hdv_divider_properties.sv ----
// hdv_divider_properties: port-level checks on the divider.
// assumes only the top module's ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module hdv_divider_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_divisor_wr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_ovf_clr,
  input wire logic o_rd_valid,
  input wire logic o_busy,
  input wire logic o_overflow
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // a start with a zero divisor
  sequence s_zero_go;
    i_divisor_wr && i_wr_data == 32'h0;
  endsequence
  a_start_busy: assert property (i_divisor_wr |=> o_busy) else $error("no busy");
  a_busy_hold: assert property (i_divisor_wr && i_wr_data != 32'h0 |=> o_busy [*8]) else $error("short");
  a_zero_ovf: assert property (s_zero_go |=> o_overflow) else $error("no overflow");
  a_zero_short: assert property (s_zero_go ##1 !i_divisor_wr |=> !o_busy) else $error("zero run long");
  a_ovf_sticky: assert property (o_overflow && !i_ovf_clr |=> o_overflow) else $error("flag lost");
  a_ovf_clear: assert property (i_ovf_clr && !(i_divisor_wr && i_wr_data == 32'h0) |=> !o_overflow)
    else $error("flag kept");
  a_read_held: assert property (o_rd_valid |-> !o_busy) else $error("read while busy");
  a_valid_pulse: assert property (o_rd_valid |=> !o_rd_valid) else $error("long valid");
endmodule : hdv_divider_chk
bind hdv_divider hdv_divider_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_divisor_wr(i_divisor_wr),
  .i_wr_data(i_wr_data), .i_ovf_clr(i_ovf_clr), .o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_overflow(o_overflow));
`default_nettype wire

// ---- verif/hdv_core_model.sv ----
// hdv_core_model: the processor side issuing result reads.
// assumes one read outstanding; the bench calls read().
`timescale 1ns/1ps
`default_nettype none
module hdv_core_model (
  input wire logic i_sys_clk,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data,
  output logic o_rd_req,
  output logic [2:0] o_rd_sel
);
  initial begin
    o_rd_req = 1'b0;
    o_rd_sel = 3'h0;
  end
  // pulse the request, hold the selector, wait a bounded time for the answer
  task automatic read(input logic [2:0] sel, output logic [31:0] d, output bit ok);
    @(posedge i_sys_clk); #1;
    o_rd_req = 1'b1;
    o_rd_sel = sel;
    @(posedge i_sys_clk); #1;
    o_rd_req = 1'b0;
    ok = 1'b0;
    for (int n = 0; n < 64 && !ok; n++) begin
      if (i_rd_valid === 1'b1) begin
        d = i_rd_data;
        ok = 1'b1;
      end else begin
        @(posedge i_sys_clk); #1;
      end
    end
  endtask : read
endmodule : hdv_core_model
`default_nettype wire

// ---- verif/hdv_divider_tb.sv ----
// hdv_divider_tb: self-checking bench for the divider.
// assumes hdv_pkg, the core model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module hdv_divider_tb;
  import hdv_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, dvd_wr = 0, dvs_wr = 0, sgn = 0, clr = 0, rd_req, rd_valid, busy, ovf;
  logic [2:0] rd_sel;
  logic [31:0] wdata = 32'h0, rdata;
  int errors = 0, comparisons = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  hdv_divider u_hdv_divider (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_dividend_wr(dvd_wr),
    .i_divisor_wr(dvs_wr), .i_wr_data(wdata), .i_signedness_select(sgn), .i_rd_req(rd_req),
    .i_rd_sel(rd_sel), .o_rd_valid(rd_valid), .o_rd_data(rdata), .i_ovf_clr(clr), .o_busy(busy), .o_overflow(ovf));
  hdv_core_model u_hdv_core_model (.i_sys_clk(i_sys_clk), .i_rd_valid(rd_valid), .i_rd_data(rdata),
    .o_rd_req(rd_req), .o_rd_sel(rd_sel));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // a lost answer ends the run at once
  task automatic rd(input logic [2:0] sel, input logic [31:0] exp);
    logic [31:0] d;
    bit ok;
    u_hdv_core_model.read(sel, d, ok);
    if (!ok) begin
      errors++;
      tally_and_finish;
    end
    check(d, exp);
  endtask : rd
  // dividend and divisor on back-to-back edges, then busy must show
  task automatic div(input logic [31:0] a, input logic [31:0] b, input logic s);
    @(posedge i_sys_clk); #1;
    dvd_wr = 1; wdata = a;
    @(posedge i_sys_clk); #1;
    dvd_wr = 0; dvs_wr = 1; wdata = b; sgn = s;
    @(posedge i_sys_clk); #1;
    dvs_wr = 0;
    check({31'h0, busy}, 32'h1);
  endtask : div
  // same operands both ways, so signedness shows in the result; reads go out mid-run and are held until it ends
  task automatic t_signs;
    div(32'hFFFF_FFF0, 32'h7, 1'b0);
    rd(HDV_SEL_QUOTIENT, 32'h2492_4922);
    rd(HDV_SEL_REMAINDER, 32'h2);
    rd(HDV_SEL_DIVIDEND, 32'hFFFF_FFF0);
    rd(HDV_SEL_DIVISOR, 32'h7);
    div(32'hFFFF_FFF0, 32'h7, 1'b1);
    rd(HDV_SEL_QUOTIENT, 32'hFFFF_FFFE);
    rd(HDV_SEL_REMAINDER, 32'hFFFF_FFFE);
    $display("t_signs done");
  endtask : t_signs
  // zero divisor: flag rises, survives reads, falls only on clear
  task automatic t_zero;
    div(32'h1234_5678, 32'h0, 1'b0);
    check({31'h0, ovf}, 32'h1);
    rd(HDV_SEL_REMAINDER, 32'h1234_5678);
    rd(HDV_SEL_STATUS, 32'h2);
    @(posedge i_sys_clk); #1;
    clr = 1;
    @(posedge i_sys_clk); #1;
    clr = 0;
    rd(HDV_SEL_STATUS, 32'h0);
    $display("t_zero done");
  endtask : t_zero
  // restart mid-run with both strobes in one cycle: one word is dividend and divisor
  task automatic t_restart;
    div(32'h0000_0064, 32'h0000_0003, 1'b0);
    @(posedge i_sys_clk); #1;
    dvd_wr = 1; dvs_wr = 1; wdata = 32'h0000_0009;
    @(posedge i_sys_clk); #1;
    dvd_wr = 0; dvs_wr = 0;
    rd(HDV_SEL_QUOTIENT, 32'h0000_0001);
    rd(HDV_SEL_REMAINDER, 32'h0000_0000);
    rd(3'h7, 32'h0000_0000);
    $display("t_restart done");
  endtask : t_restart
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    t_signs;
    t_zero;
    t_restart;
    tally_and_finish;
  end
endmodule : hdv_divider_tb
`default_nettype wire
